// [verilog/cbcs_defs.svh]
// Purpose: constants of the bus cycle sequencer
// Assumes: one clock, active-low asynchronous reset
// Notes: status encodings are {io_mem_sel, hi, lo}
`ifndef CBCS_DEFS_SVH
`define CBCS_DEFS_SVH
`define CBCS_ST_FETCH 3'h3
`define CBCS_ST_MRD 3'h2
`define CBCS_ST_MWR 3'h1
`define CBCS_ST_IORD 3'h6
`define CBCS_ST_IOWR 3'h5
`define CBCS_ST_INTERRUPT_ACK_STROBE_N 3'h7
`define CBCS_ST_IDLE 3'h2
`define CBCS_ST_HALT 3'h0
`define CBCS_FETCH_LONG_LEN 3'h6
`define CBCS_FETCH_SHORT_LEN 3'h4
`define CBCS_CYCLE_LEN 3'h3
`endif

// [verilog/cbcs_pkg.sv]
// Purpose: types of the bus cycle sequencer
// Assumes: included constants header
// Notes: none
package cbcs_pkg;
    typedef enum logic [2:0] {
        CBCS_OF, CBCS_MR, CBCS_MW, CBCS_IOR, CBCS_IOW, CBCS_INA, CBCS_BI
    } cbcs_cycle_t;
    typedef enum logic [3:0] {
        CBCS_T1, CBCS_T2, CBCS_T3, CBCS_T4, CBCS_T5, CBCS_T6,
        CBCS_TW, CBCS_TRESET, CBCS_THALT, CBCS_THOLD
    } cbcs_tstate_t;
    typedef struct packed {
        cbcs_cycle_t kind;
        logic long_fetch;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cbcs_req_t;
    typedef struct packed {
        logic io_mem_sel;
        logic cycle_status_hi;
        logic cycle_status_lo;
    } cbcs_status_t;
endpackage

// [verilog/cbcs_sync.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: asynchronous pins
// Notes: first stage read only by second
`timescale 1ns/1ps
module cbcs_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] sync
);
    logic [WIDTH-1:0] stage1;
    // two stages per bit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage1 <= RST_VAL;
            sync <= RST_VAL;
        end else begin
            stage1 <= pin;
            sync <= stage1;
        end
    end
endmodule

// [verilog/cbcs_sequencer.sv]
// Purpose: machine cycle and T state sequencer with bus pins
// Assumes: core hands one cycle request at a time on req_valid
// Notes: ready and hold pins pass two flops first
`timescale 1ns/1ps
`include "cbcs_defs.svh"
module cbcs_sequencer (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic req_valid,
    input cbcs_pkg::cbcs_req_t req,
    input wire logic halt_req,
    output logic req_ready,
    output logic [7:0] rdata,
    output logic rdata_valid,
    input wire logic ready_pin,
    input wire logic hold_pin,
    output logic hold_ack,
    output cbcs_pkg::cbcs_status_t status,
    output logic status_oe,
    output logic [7:0] high_address_lines,
    output logic high_address_oe,
    input wire logic [7:0] low_address_data_in,
    output logic [7:0] low_address_data_out,
    output logic low_address_data_oe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic strobe_oe,
    output logic interrupt_ack_strobe_n,
    output logic address_latch_strobe,
    output cbcs_pkg::cbcs_tstate_t tstate
);
    logic ready_s;
    logic hold_s;
    logic [7:0] din_s;
    cbcs_pkg::cbcs_req_t cur;
    cbcs_pkg::cbcs_tstate_t next_tstate;
    logic [2:0] cyc_len;
    logic is_read;
    logic is_write;
    logic is_io;
    logic in_cycle;
    logic floated;
    logic released;
    logic rd_take;

    // pins from outside pass two flops
    cbcs_sync #(.WIDTH(2), .RST_VAL(2'h1)) u_sync_ctl (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin({hold_pin, ready_pin}),
        .sync({hold_s, ready_s})
    );
    cbcs_sync #(.WIDTH(8), .RST_VAL(8'h00)) u_sync_data (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin(low_address_data_in),
        .sync(din_s)
    );

    // cycle length and kind decode
    always_comb begin
        unique case (cur.kind)
            cbcs_pkg::CBCS_OF: cyc_len = cur.long_fetch ? `CBCS_FETCH_LONG_LEN
                                                        : `CBCS_FETCH_SHORT_LEN;
            default: cyc_len = `CBCS_CYCLE_LEN;
        endcase
        is_read = cur.kind inside {cbcs_pkg::CBCS_OF, cbcs_pkg::CBCS_MR, cbcs_pkg::CBCS_IOR};
        is_write = cur.kind inside {cbcs_pkg::CBCS_MW, cbcs_pkg::CBCS_IOW};
        is_io = cur.kind inside {cbcs_pkg::CBCS_IOR, cbcs_pkg::CBCS_IOW};
    end

    assign in_cycle = tstate inside {cbcs_pkg::CBCS_T1, cbcs_pkg::CBCS_T2,
        cbcs_pkg::CBCS_TW, cbcs_pkg::CBCS_T3, cbcs_pkg::CBCS_T4,
        cbcs_pkg::CBCS_T5, cbcs_pkg::CBCS_T6};
    assign floated = tstate inside {cbcs_pkg::CBCS_TRESET, cbcs_pkg::CBCS_THALT,
        cbcs_pkg::CBCS_THOLD};
    // cycle ends at last T state; a new one may start at once
    assign released = (tstate == cbcs_pkg::CBCS_T3 && cyc_len == `CBCS_CYCLE_LEN)
        || (tstate == cbcs_pkg::CBCS_T4 && cyc_len == `CBCS_FETCH_SHORT_LEN)
        || tstate == cbcs_pkg::CBCS_T6
        || tstate == cbcs_pkg::CBCS_TRESET
        || (tstate == cbcs_pkg::CBCS_THALT && !halt_req && !hold_s)
        || (tstate == cbcs_pkg::CBCS_THOLD && !hold_s);
    assign req_ready = released && !hold_s && !halt_req;

    // next T state
    always_comb begin
        next_tstate = tstate;
        unique case (tstate)
            cbcs_pkg::CBCS_T1: next_tstate = cbcs_pkg::CBCS_T2;
            cbcs_pkg::CBCS_T2: begin
                // only transfer cycles may stretch
                if (!ready_s && cur.kind != cbcs_pkg::CBCS_BI) begin
                    next_tstate = cbcs_pkg::CBCS_TW;
                end else begin
                    next_tstate = cbcs_pkg::CBCS_T3;
                end
            end
            cbcs_pkg::CBCS_TW: next_tstate = ready_s ? cbcs_pkg::CBCS_T3
                                                     : cbcs_pkg::CBCS_TW;
            cbcs_pkg::CBCS_T4: next_tstate = released ? cbcs_pkg::CBCS_THOLD
                                                      : cbcs_pkg::CBCS_T5;
            cbcs_pkg::CBCS_T5: next_tstate = cbcs_pkg::CBCS_T6;
            default: next_tstate = cbcs_pkg::CBCS_THOLD;
        endcase
        if (tstate == cbcs_pkg::CBCS_T3 && cyc_len != `CBCS_CYCLE_LEN) begin
            next_tstate = cbcs_pkg::CBCS_T4;
        end
        if (released || tstate == cbcs_pkg::CBCS_THALT || tstate == cbcs_pkg::CBCS_THOLD) begin
            if (hold_s) begin
                next_tstate = cbcs_pkg::CBCS_THOLD;
            end else if (halt_req) begin
                next_tstate = cbcs_pkg::CBCS_THALT;
            end else if (req_valid) begin
                next_tstate = cbcs_pkg::CBCS_T1;
            end else if (tstate == cbcs_pkg::CBCS_THALT) begin
                next_tstate = cbcs_pkg::CBCS_THALT;
            end else begin
                next_tstate = cbcs_pkg::CBCS_THOLD;
            end
        end
    end

    // sequencer state, one of ten
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tstate <= cbcs_pkg::CBCS_TRESET;
        end else begin
            tstate <= next_tstate;
        end
    end

    // request capture at cycle start
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else if (req_valid && req_ready) begin
            cur <= req;
        end
    end

    // hold acknowledge while bus released
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hold_ack <= 1'b0;
        end else begin
            hold_ack <= (next_tstate == cbcs_pkg::CBCS_THOLD) && hold_s;
        end
    end

    // status lines: driven from T1 through the cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            status <= '0;
        end else if (next_tstate == cbcs_pkg::CBCS_THALT) begin
            status <= `CBCS_ST_HALT;
        end else if (req_valid && req_ready && next_tstate == cbcs_pkg::CBCS_T1) begin
            unique case (req.kind)
                cbcs_pkg::CBCS_OF: status <= `CBCS_ST_FETCH;
                cbcs_pkg::CBCS_MR: status <= `CBCS_ST_MRD;
                cbcs_pkg::CBCS_MW: status <= `CBCS_ST_MWR;
                cbcs_pkg::CBCS_IOR: status <= `CBCS_ST_IORD;
                cbcs_pkg::CBCS_IOW: status <= `CBCS_ST_IOWR;
                cbcs_pkg::CBCS_INA: status <= `CBCS_ST_INTERRUPT_ACK_STROBE_N;
                default: status <= `CBCS_ST_IDLE;
            endcase
        end
    end
    assign status_oe = !(tstate inside {cbcs_pkg::CBCS_TRESET, cbcs_pkg::CBCS_THALT,
        cbcs_pkg::CBCS_THOLD});

    // address, data and strobes from flops
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            high_address_lines <= 8'h00;
            low_address_data_out <= 8'h00;
            address_latch_strobe <= 1'b0;
        end else if (req_valid && req_ready && next_tstate == cbcs_pkg::CBCS_T1) begin
            // port address copied on both halves
            high_address_lines <= req.kind inside {cbcs_pkg::CBCS_IOR, cbcs_pkg::CBCS_IOW}
                ? req.addr[7:0] : req.addr[15:8];
            low_address_data_out <= req.addr[7:0];
            address_latch_strobe <= req.kind != cbcs_pkg::CBCS_BI;
        end else begin
            address_latch_strobe <= 1'b0;
            if (next_tstate == cbcs_pkg::CBCS_T2) begin
                low_address_data_out <= cur.wdata;
            end
        end
    end

    // read/write strobes from T2 through last wait
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            interrupt_ack_strobe_n <= 1'b1;
        end else begin
            read_strobe_n <= !(is_read && (next_tstate inside {cbcs_pkg::CBCS_T2,
                cbcs_pkg::CBCS_TW}));
            write_strobe_n <= !(is_write && (next_tstate inside {cbcs_pkg::CBCS_T2,
                cbcs_pkg::CBCS_TW}));
            interrupt_ack_strobe_n <= !(cur.kind == cbcs_pkg::CBCS_INA
                && (next_tstate inside {cbcs_pkg::CBCS_T2, cbcs_pkg::CBCS_TW}));
        end
    end

    // enables: float in reset, halt, hold
    assign high_address_oe = in_cycle;
    assign low_address_data_oe = (tstate == cbcs_pkg::CBCS_T1)
        || (is_write && tstate inside {cbcs_pkg::CBCS_T2, cbcs_pkg::CBCS_TW,
        cbcs_pkg::CBCS_T3});
    assign strobe_oe = !floated;

    // read data: the pin seen in T2 reaches din_s only after T3, so take it one later
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata <= 8'h00;
            rdata_valid <= 1'b0;
            rd_take <= 1'b0;
        end else begin
            rd_take <= (tstate == cbcs_pkg::CBCS_T3) && (is_read
                || cur.kind == cbcs_pkg::CBCS_INA);
            rdata_valid <= rd_take;
            if (rd_take) begin
                rdata <= din_s;
            end
        end
    end

    sequence s_t1;
        tstate == cbcs_pkg::CBCS_T1;
    endsequence
    sequence s_t2_t3;
        tstate == cbcs_pkg::CBCS_T2 ##1 tstate == cbcs_pkg::CBCS_T3;
    endsequence

    AST_ALE_T1: assert property (@(posedge clk_sys) disable iff (!nrst)
        address_latch_strobe |-> tstate == cbcs_pkg::CBCS_T1)
        else $error("latch strobe outside T1");
    AST_NO_STROBE_T1: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_t1 |-> read_strobe_n && write_strobe_n)
        else $error("strobe active in T1");
    AST_STATUS_STABLE: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_t1 ##1 tstate == cbcs_pkg::CBCS_T2 |-> $stable(status))
        else $error("status changed after T1");
    AST_THREE_T: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_t1 ##0 cur.kind == cbcs_pkg::CBCS_MR ##1 s_t2_t3 |=>
        tstate != cbcs_pkg::CBCS_T4)
        else $error("read cycle exceeds three T states");
    AST_WAIT: assert property (@(posedge clk_sys) disable iff (!nrst)
        tstate == cbcs_pkg::CBCS_TW && !ready_s |=> tstate == cbcs_pkg::CBCS_TW)
        else $error("wait left with ready low");
    AST_WAIT_STROBE: assert property (@(posedge clk_sys) disable iff (!nrst)
        tstate == cbcs_pkg::CBCS_TW && is_read |-> !read_strobe_n)
        else $error("read strobe not stretched");
    AST_FLOAT: assert property (@(posedge clk_sys) disable iff (!nrst)
        floated |-> !low_address_data_oe && !high_address_oe && !strobe_oe
        && interrupt_ack_strobe_n && !address_latch_strobe)
        else $error("bus driven while floated");
    AST_IDLE_NO_ALE: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_t1 ##0 cur.kind == cbcs_pkg::CBCS_BI |-> !address_latch_strobe
        && read_strobe_n && write_strobe_n)
        else $error("idle cycle pulsed a strobe");
    AST_IO_ADDR: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_t1 ##0 is_io |-> high_address_lines == low_address_data_out)
        else $error("port address not copied");
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        hold_ack |-> !low_address_data_oe && !high_address_oe)
        else $error("bus driven under hold acknowledge");
    AST_STATUS_OF: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_t1 ##0 cur.kind == cbcs_pkg::CBCS_OF |-> status == `CBCS_ST_FETCH)
        else $error("fetch status wrong");

    // boundary, strobe and read data timing
    AST_WR_T2: assert property (@(posedge clk_sys) disable iff (!nrst)
        tstate == cbcs_pkg::CBCS_T2 && is_write |-> !write_strobe_n && read_strobe_n)
        else $error("write strobe missing in T2");
    AST_INTERRUPT_ACK_STROBE_N_T2: assert property (@(posedge clk_sys) disable iff (!nrst)
        tstate == cbcs_pkg::CBCS_T2 && cur.kind == cbcs_pkg::CBCS_INA |-> !interrupt_ack_strobe_n)
        else $error("acknowledge strobe missing in T2");
    AST_SHORT_FETCH: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_t1 ##0 cur.kind == cbcs_pkg::CBCS_OF && !cur.long_fetch ##1 s_t2_t3
        ##1 tstate == cbcs_pkg::CBCS_T4 |=> tstate != cbcs_pkg::CBCS_T5)
        else $error("short fetch ran past four T states");
    AST_NO_MID_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        in_cycle && !released |=> tstate != cbcs_pkg::CBCS_THOLD)
        else $error("bus released in mid cycle");
    AST_RD_VALID: assert property (@(posedge clk_sys) disable iff (!nrst)
        tstate == cbcs_pkg::CBCS_T3 && is_read |=> ##1 rdata_valid)
        else $error("read data not handed over");
endmodule

// [tb/cbcs_mem_model.sv]
// Purpose: memory, i/o ports and glue logic facing the bus cycle sequencer
// Assumes: bench sets slow to hold ready low while it wants wait states
// Notes: released data lines show the inverse of their last value
`timescale 1ns/1ps
module cbcs_mem_model #(
    parameter logic [7:0] INA_VEC = 8'hC7
) (
    input wire logic clk_sys,
    input wire logic slow,
    input cbcs_pkg::cbcs_status_t status,
    input wire logic [7:0] high_address_lines,
    input wire logic [7:0] low_address_data_out,
    input wire logic low_address_data_oe,
    input wire logic address_latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic strobe_oe,
    input wire logic interrupt_ack_strobe_n,
    output logic ready_pin,
    output logic [7:0] low_address_data_in
);
    logic [7:0] mem [256];
    logic [7:0] io [256];
    logic [7:0] per;
    logic [7:0] low_lat = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] rd;
    logic per_sel;
    logic rd_act;
    int hold_cnt = 0;
    // same start contents as the bench mirror
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = i[7:0] ^ 8'h5A;
            io[i] = ~i[7:0];
        end
        per = 8'h3C;
    end
    // external latch keeps low address once the shared lines turn to data
    always @(posedge clk_sys) begin
        if (address_latch_strobe) begin
            low_lat <= low_address_data_out;
        end
    end
    // memory region at high byte f0 decoded onto a peripheral register
    assign per_sel = !status.io_mem_sel && high_address_lines == 8'hF0;
    assign rd = status.io_mem_sel ? io[low_lat] : (per_sel ? per : mem[low_lat]);
    assign rd_act = (strobe_oe && !read_strobe_n) || !interrupt_ack_strobe_n;
    // data kept two cycles past the strobe as hold time, then released
    always @(posedge clk_sys) begin
        hold_cnt <= rd_act ? 2 : (hold_cnt > 0 ? hold_cnt - 1 : 0);
        last <= low_address_data_in;
    end
    always_comb begin
        if (low_address_data_oe) begin
            low_address_data_in = low_address_data_out;
        end else if (rd_act || hold_cnt > 0) begin
            low_address_data_in = !interrupt_ack_strobe_n ? INA_VEC : rd;
        end else begin
            low_address_data_in = ~last;
        end
    end
    // write data taken while the write strobe is low
    always @(posedge clk_sys) begin
        if (strobe_oe && !write_strobe_n && low_address_data_oe) begin
            if (status.io_mem_sel) io[low_lat] <= low_address_data_out;
            else if (per_sel) per <= low_address_data_out;
            else mem[low_lat] <= low_address_data_out;
        end
    end
    // slow device stretches the cycle by holding ready low
    assign ready_pin = !slow;
endmodule

// [tb/cpu_bus_cycle_sequencer_tb_top.sv]
// Purpose: self-checking bench of the bus cycle sequencer
// Assumes: requests driven 1 ns after the rising edge, outputs read at falling edge
// Notes: mirror arrays and queues predict every cycle and every read
`timescale 1ns/1ps
`include "cbcs_defs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module cpu_bus_cycle_sequencer_tb_top;
    localparam logic [7:0] INA_VEC = 8'hC7;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    cbcs_pkg::cbcs_req_t req = '0;
    logic halt_req = 1'b0;
    logic hold_pin = 1'b0;
    logic slow = 1'b0;
    logic req_ready, rdata_valid, ready_pin, hold_ack, status_oe, high_address_oe;
    logic low_address_data_oe, read_strobe_n, write_strobe_n, strobe_oe;
    logic interrupt_ack_strobe_n, address_latch_strobe;
    logic [7:0] rdata, high_address_lines, low_address_data_in, low_address_data_out;
    cbcs_pkg::cbcs_status_t status;
    cbcs_pkg::cbcs_tstate_t tstate;
    int error_cnt = 0;
    int checks = 0;
    int seed = 32'hFB832A4D;
    logic [7:0] em [256];
    logic [7:0] eio [256];
    logic [7:0] eper = 8'h3C;
    cbcs_pkg::cbcs_req_t eq [$];
    logic [7:0] rq [$];
    logic [7:0] exp_rd;
    cbcs_pkg::cbcs_req_t cur;
    logic act = 1'b0;
    logic saw_w = 1'b0;
    logic [2:0] len = 3'h0;
    always #5 clk_sys = ~clk_sys;
    cbcs_sequencer cbcs_sequencer_inst (.clk_sys(clk_sys), .nrst(nrst),
        .req_valid(req_valid), .req(req), .halt_req(halt_req), .req_ready(req_ready),
        .rdata(rdata), .rdata_valid(rdata_valid), .ready_pin(ready_pin),
        .hold_pin(hold_pin), .hold_ack(hold_ack), .status(status), .status_oe(status_oe),
        .high_address_lines(high_address_lines), .high_address_oe(high_address_oe),
        .low_address_data_in(low_address_data_in),
        .low_address_data_out(low_address_data_out),
        .low_address_data_oe(low_address_data_oe), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .strobe_oe(strobe_oe),
        .interrupt_ack_strobe_n(interrupt_ack_strobe_n),
        .address_latch_strobe(address_latch_strobe), .tstate(tstate));
    cbcs_mem_model #(.INA_VEC(INA_VEC)) cbcs_mem_model_inst (.clk_sys(clk_sys),
        .slow(slow), .status(status), .high_address_lines(high_address_lines),
        .low_address_data_out(low_address_data_out),
        .low_address_data_oe(low_address_data_oe),
        .address_latch_strobe(address_latch_strobe), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .strobe_oe(strobe_oe),
        .interrupt_ack_strobe_n(interrupt_ack_strobe_n), .ready_pin(ready_pin),
        .low_address_data_in(low_address_data_in));
    // status code of each cycle kind
    function automatic logic [2:0] st(input cbcs_pkg::cbcs_cycle_t k);
        case (k)
            cbcs_pkg::CBCS_OF: return `CBCS_ST_FETCH;
            cbcs_pkg::CBCS_MR: return `CBCS_ST_MRD;
            cbcs_pkg::CBCS_MW: return `CBCS_ST_MWR;
            cbcs_pkg::CBCS_IOR: return `CBCS_ST_IORD;
            cbcs_pkg::CBCS_IOW: return `CBCS_ST_IOWR;
            cbcs_pkg::CBCS_INA: return `CBCS_ST_INTERRUPT_ACK_STROBE_N;
            default: return `CBCS_ST_IDLE;
        endcase
    endfunction
    // strobes {read, write, interrupt_ack_strobe_n} while the transfer runs
    function automatic logic [2:0] sb(input cbcs_pkg::cbcs_cycle_t k);
        case (k)
            cbcs_pkg::CBCS_OF, cbcs_pkg::CBCS_MR, cbcs_pkg::CBCS_IOR: return 3'h3;
            cbcs_pkg::CBCS_MW, cbcs_pkg::CBCS_IOW: return 3'h5;
            cbcs_pkg::CBCS_INA: return 3'h6;
            default: return 3'h7;
        endcase
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // one request held until taken, then the mirror is updated
    task automatic do_req(input cbcs_pkg::cbcs_cycle_t k, input logic [15:0] a,
                          input logic [7:0] w);
        logic [31:0] tmp;
        int i;
        tmp = $random(seed);
        req_valid = 1'b1;
        req = '{kind: k, long_fetch: tmp[0], addr: a, wdata: w};
        for (i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            if (req_ready === 1'b1) break;
        end
        `CHK("req_taken", 1'b1, req_ready)
        @(posedge clk_sys);
        #1;
        eq.push_back(req);
        case (k)
            cbcs_pkg::CBCS_OF, cbcs_pkg::CBCS_MR:
                rq.push_back(a[15:8] == 8'hF0 ? eper : em[a[7:0]]);
            cbcs_pkg::CBCS_MW: if (a[15:8] == 8'hF0) eper = w; else em[a[7:0]] = w;
            cbcs_pkg::CBCS_IOR: rq.push_back(eio[a[7:0]]);
            cbcs_pkg::CBCS_IOW: eio[a[7:0]] = w;
            cbcs_pkg::CBCS_INA: rq.push_back(INA_VEC);
            default: ;
        endcase
    endtask
    task automatic chk_float();
        `CHK("bus_oe", 4'h0, {status_oe, high_address_oe, low_address_data_oe, strobe_oe})
        `CHK("interrupt_ack_strobe_n_ale", 2'h2, {interrupt_ack_strobe_n, address_latch_strobe})
    endtask
    // cycle monitor: status, latch strobe, strobes, length, read data
    always @(negedge clk_sys) begin
        if (nrst) begin
            `CHK("tstate_valid", 1'b1, tstate inside {[cbcs_pkg::CBCS_T1:cbcs_pkg::CBCS_THOLD]})
            if (tstate == cbcs_pkg::CBCS_T1) begin
                if (act) `CHK("cycle_len", cur.kind == cbcs_pkg::CBCS_OF ?
                    (cur.long_fetch ? 3'h6 : 3'h4) : 3'h3, len)
                if (eq.size() == 0) `CHK("cycle_requested", 1'b1, 1'b0)
                else cur = eq.pop_front();
                act = 1'b1;
                len = 3'h1;
                `CHK("status", st(cur.kind), status)
                `CHK("ale", cur.kind != cbcs_pkg::CBCS_BI, address_latch_strobe)
                `CHK("t1_strobes", 3'h7, {read_strobe_n, write_strobe_n, interrupt_ack_strobe_n})
                `CHK("t1_oe", 4'hF, {status_oe, high_address_oe, low_address_data_oe, strobe_oe})
                if (cur.kind != cbcs_pkg::CBCS_BI) begin
                    `CHK("low_addr", cur.addr[7:0], low_address_data_out)
                    `CHK("high_addr", (cur.kind inside {cbcs_pkg::CBCS_IOR, cbcs_pkg::CBCS_IOW})
                        ? cur.addr[7:0] : cur.addr[15:8], high_address_lines)
                end
            end else if (act && tstate inside {[cbcs_pkg::CBCS_T2:cbcs_pkg::CBCS_TW]}) begin
                if (tstate == cbcs_pkg::CBCS_TW) saw_w = 1'b1;
                else len = len + 3'h1;
                if (tstate inside {cbcs_pkg::CBCS_T2, cbcs_pkg::CBCS_TW})
                    `CHK("strobes", sb(cur.kind), {read_strobe_n, write_strobe_n, interrupt_ack_strobe_n})
                if (tstate inside {cbcs_pkg::CBCS_T2, cbcs_pkg::CBCS_TW})
                    `CHK("ad_drive", cur.kind inside {cbcs_pkg::CBCS_MW, cbcs_pkg::CBCS_IOW},
                        low_address_data_oe)
            end else if (act) begin
                `CHK("cycle_len", cur.kind == cbcs_pkg::CBCS_OF ?
                    (cur.long_fetch ? 3'h6 : 3'h4) : 3'h3, len)
                act = 1'b0;
            end
            if (rdata_valid === 1'b1) begin
                if (rq.size() == 0) `CHK("read_expected", 1'b1, 1'b0)
                else begin
                    exp_rd = rq.pop_front();
                    `CHK("rdata", exp_rd, rdata)
                end
            end
        end
    end
    // watchdog sized well above the few hundred cycles of the tests
    initial begin
        #100000;
        error_cnt++;
        $display("[ERR] watchdog expected done seen hang");
        end_sim();
    end
    initial begin
        logic [31:0] tmp;
        cbcs_pkg::cbcs_cycle_t k;
        int i;
        for (i = 0; i < 256; i++) begin
            em[i] = i[7:0] ^ 8'h5A;
            eio[i] = ~i[7:0];
        end
        repeat (19) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_float();
        @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        idle(2);
        // every cycle kind back to back with random addresses
        for (int r = 0; r < 3; r++) begin
            for (int j = 0; j < 7; j++) begin
                tmp = $random(seed);
                k = cbcs_pkg::cbcs_cycle_t'(j[2:0]);
                do_req(k, tmp[15:0], tmp[23:16]);
            end
        end
        $display("test kinds done");
        // mapped peripheral, plain memory and port at the same low address
        do_req(cbcs_pkg::CBCS_MW, 16'hF012, 8'hA5);
        do_req(cbcs_pkg::CBCS_MW, 16'h3412, 8'h96);
        do_req(cbcs_pkg::CBCS_IOW, 16'h1212, 8'h69);
        do_req(cbcs_pkg::CBCS_MR, 16'hF012, 8'h00);
        do_req(cbcs_pkg::CBCS_OF, 16'h3412, 8'h00);
        do_req(cbcs_pkg::CBCS_IOR, 16'h1212, 8'h00);
        req_valid = 1'b0;
        idle(8);
        $display("test mapping done");
        // slow device: ready held low stretches a read
        slow = 1'b1;
        idle(3);
        do_req(cbcs_pkg::CBCS_MR, 16'h0077, 8'h00);
        req_valid = 1'b0;
        idle(8);
        slow = 1'b0;
        idle(10);
        `CHK("wait_seen", 1'b1, saw_w)
        $display("test wait done");
        // hold raised during a write: cycle ends, then buses float
        do_req(cbcs_pkg::CBCS_MW, 16'h0120, 8'h5E);
        req_valid = 1'b0;
        hold_pin = 1'b1;
        for (i = 0; i < 30 && hold_ack !== 1'b1; i++) @(negedge clk_sys);
        `CHK("hold_ack", 1'b1, hold_ack)
        `CHK("hold_state", cbcs_pkg::CBCS_THOLD, tstate)
        chk_float();
        idle(1);
        hold_pin = 1'b0;
        idle(4);
        $display("test hold done");
        // halt, then a read shows the core resumes
        halt_req = 1'b1;
        for (i = 0; i < 30 && tstate !== cbcs_pkg::CBCS_THALT; i++) @(negedge clk_sys);
        `CHK("halt_state", cbcs_pkg::CBCS_THALT, tstate)
        `CHK("halt_status", `CBCS_ST_HALT, {status.cycle_status_hi, status.cycle_status_lo})
        chk_float();
        idle(1);
        halt_req = 1'b0;
        do_req(cbcs_pkg::CBCS_MR, 16'h0120, 8'h00);
        req_valid = 1'b0;
        idle(10);
        $display("test halt done");
        end_sim();
    end
endmodule
